// ===== shared/supply_mon_pkg.sv
// Purpose: Shared constants and carriers for the supply and temperature monitor.
// Assumes: Registers are byte wide and addressed by a 7-bit register address.
// Notes: Offsets are the register addresses seen by the serial host.
`default_nettype none
package supply_mon_pkg;
   localparam int unsigned CODE_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam logic [6:0] gate_drive_supply_setting_addr = 7'h15;
   localparam logic [6:0] high_supply_threshold_addr = 7'h1a;
   localparam logic [6:0] low_supply_threshold_addr = 7'h1b;
   localparam logic [6:0] battery_measurement_addr = 7'h45;
   localparam logic [6:0] die_temperature_addr = 7'h46;
   localparam logic [6:0] diag_status_addr = 7'h58;
   localparam int unsigned LOW_FLAG_BIT = 3;
   localparam int unsigned HIGH_FLAG_BIT = 2;
   localparam int unsigned GOOD_BIT = 5;
   localparam logic [7:0] GATE_CODE_MAX_V = 8'h5d;
   localparam logic [7:0] GATE_CODE_MIN_V = 8'hb7;
   localparam logic [7:0] GATE_CODE_RST = 8'hb7;
   localparam logic [7:0] HIGH_LIMIT_RST = 8'hff;
   localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam int unsigned SAMPLE_CYCLES = 1;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic above;
      logic below;
   } cmp_s;
endpackage
`default_nettype wire

// ===== src/limit_compare.sv
// Purpose: Compares a raw measurement code against raw low and high limits.
// Assumes: Both codes share one scale, so no correction is applied here.
// Notes: Purely combinational.
`default_nettype none
module limit_compare #(
   parameter int unsigned W = 8
) (
   // Codes
   input wire logic [W-1:0] meas,
   input wire logic [W-1:0] low_lim,
   input wire logic [W-1:0] high_lim,
   // Result
   output var supply_mon_pkg::cmp_s res
);
   if (W < 1) begin : g_bad_width
      $error("W must be at least 1.");
   end

   always_comb begin
      res.below = meas < low_lim; // see (R14)
      res.above = meas > high_lim; // see (R14)
   end
endmodule
`default_nettype wire

// ===== src/supply_and_temp_monitor.sv
// Purpose: Gate supply code, battery monitor with limits, die temperature readout.
// Assumes: Measurement codes arrive from converters on other clocks or pins.
// Notes: Fail-silent stays latched until off mode.
// Notes: Converter words are taken only after two matching samples.
// What this block does
// (R01) Hold 8-bit gate supply code; 5Dh highest voltage, B7h lowest.
// (R02) Host never writes gate codes below 5Dh and reads back each write.
// (R03) Host avoids gate codes above B7h; supply may not start.
// (R04) Measure battery only with an output enabled and gate supply good.
// (R05) Supply flags come from the measurement, valid only with outputs enabled.
// (R06) Battery code is read-only, 0 V to 90 V at 0.3555 V per step.
// (R07) Below low limit: set low flag, enter fail-silent, stop gates.
// (R08) Low limit is an 8-bit code on the measurement scale.
// (R09) Above high limit: set high flag, enter fail-silent, stop gates.
// (R10) High limit is an 8-bit code on the measurement scale.
// (R11) Die temperature is a read-only 8-bit code.
// (R12) Low flag at status bit 3, high flag at bit 2, one when detected.
// (R13) Status write or off mode clears flags; fail-silent persists. Here off mode also clears fail-silent; a status write leaves it set.
// (R14) Compare raw measurement code against raw limit codes.
`default_nettype none
module supply_and_temp_monitor #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Register access from the serial front end
   input wire supply_mon_pkg::reg_req_s req,
   output logic [7:0] rdata,
   // Converter and mode inputs
   input wire logic [W-1:0] battery_code_in,
   input wire logic [W-1:0] temp_code_in,
   input wire logic gate_supply_good,
   input wire logic outputs_enabled,
   input wire logic off_mode,
   // Control outputs
   output logic [7:0] gate_supply_code,
   output logic fail_silent,
   output logic gates_run,
   output logic low_supply_flag,
   output logic high_supply_flag
);
   // Register codes, the address and the status bits are fixed by the register map.
   if (W != 8) begin : g_bad_width
      $error("Register codes are 8 bits wide.");
   end
   if (supply_mon_pkg::ADDR_W != 7) begin : g_bad_addr
      $error("Register addresses are 7 bits wide.");
   end
   if (supply_mon_pkg::LOW_FLAG_BIT > 7 || supply_mon_pkg::HIGH_FLAG_BIT > 7 ||
         supply_mon_pkg::GOOD_BIT > 7) begin : g_bad_bits
      $error("Status bits must lie inside one byte.");
   end
   if (supply_mon_pkg::LOW_FLAG_BIT == supply_mon_pkg::HIGH_FLAG_BIT) begin : g_same_bits
      $error("Low and high flags need bits of their own.");
   end

   // All state lives in one record; one comb block fills the next copy.
   typedef struct packed {
      logic [W-1:0] bat_s1;
      logic [W-1:0] bat_s2;
      logic [W-1:0] bat_s3;
      logic [W-1:0] tmp_s1;
      logic [W-1:0] tmp_s2;
      logic [W-1:0] tmp_s3;
      logic [1:0] good_s;
      logic [W-1:0] gate_code;
      logic [W-1:0] high_lim;
      logic [W-1:0] low_lim;
      logic [W-1:0] bat_meas;
      logic [W-1:0] die_temp;
      logic low_flag;
      logic high_flag;
      logic fsilent;
      logic meas_valid;
      logic [7:0] rdata;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   supply_mon_pkg::cmp_s cmp;
   logic monitor_on;
   logic bat_steady;
   logic tmp_steady;
   logic compare_on;
   logic [7:0] status_byte;

   // Raw codes share one scale, so the compare needs no temperature correction.
   limit_compare #(.W(W)) u_cmp (
      .meas(st_r.bat_meas),
      .low_lim(st_r.low_lim),
      .high_lim(st_r.high_lim),
      .res(cmp)
   );

   // A converter word may be caught while its bits change; it is taken only once two
   // successive samples agree, so a torn code never reaches a register or the compare.
   assign bat_steady = (st_r.bat_s2 == st_r.bat_s3);
   assign tmp_steady = (st_r.tmp_s2 == st_r.tmp_s3);
   assign monitor_on = outputs_enabled && st_r.good_s[1]; // see (R04)
   // The compare waits for one fresh capture, so a stale or reset code never trips it.
   assign compare_on = monitor_on && st_r.meas_valid; // see (R05)

   // Status byte as the host reads it; unused bits read as zero.
   always_comb begin
      status_byte = 8'h00;
      status_byte[supply_mon_pkg::LOW_FLAG_BIT] = st_r.low_flag; // see (R12)
      status_byte[supply_mon_pkg::HIGH_FLAG_BIT] = st_r.high_flag; // see (R12)
      status_byte[supply_mon_pkg::GOOD_BIT] = st_r.good_s[1];
   end

   always_comb begin
      st_nxt = st_r;
      // The gate supply good pin passes two flops (converter codes three); the first flop never feeds any logic.
      st_nxt.bat_s1 = battery_code_in;
      st_nxt.bat_s2 = st_r.bat_s1;
      st_nxt.bat_s3 = st_r.bat_s2;
      st_nxt.tmp_s1 = temp_code_in;
      st_nxt.tmp_s2 = st_r.tmp_s1;
      st_nxt.tmp_s3 = st_r.tmp_s2;
      st_nxt.good_s = {st_r.good_s[0], gate_supply_good};
      if (tmp_steady) begin
         st_nxt.die_temp = st_r.tmp_s2; // see (R11)
      end

      st_nxt.meas_valid = 1'b0;
      if (monitor_on) begin
         st_nxt.meas_valid = st_r.meas_valid;
         if (bat_steady) begin
            st_nxt.bat_meas = st_r.bat_s2; // see (R04) see (R06)
            st_nxt.meas_valid = 1'b1;
         end
      end

      // Writes to read-only or unmapped addresses are dropped.
      if (req.wr) begin
         unique case (req.addr)
            supply_mon_pkg::gate_drive_supply_setting_addr: begin
               st_nxt.gate_code = req.wdata; // see (R01)
            end
            supply_mon_pkg::high_supply_threshold_addr: begin
               st_nxt.high_lim = req.wdata; // see (R10)
            end
            supply_mon_pkg::low_supply_threshold_addr: begin
               st_nxt.low_lim = req.wdata; // see (R08)
            end
            supply_mon_pkg::diag_status_addr: begin
               st_nxt.low_flag = 1'b0; // see (R13)
               st_nxt.high_flag = 1'b0; // see (R13)
            end
            default: begin
            end
         endcase
      end

      // Off mode clears flags and fail-silent, and that clear wins over a detection.
      if (off_mode) begin
         st_nxt.low_flag = 1'b0; // see (R13)
         st_nxt.high_flag = 1'b0; // see (R13)
         st_nxt.fsilent = 1'b0;
      end else if (compare_on) begin
         // A detection in the clearing cycle wins over the clear.
         if (cmp.below) begin
            st_nxt.low_flag = 1'b1; // see (R05) see (R07)
            st_nxt.fsilent = 1'b1; // see (R07)
         end
         if (cmp.above) begin
            st_nxt.high_flag = 1'b1; // see (R05) see (R09)
            st_nxt.fsilent = 1'b1; // see (R09)
         end
      end

      // Read data stands for one cycle and is zero between reads.
      st_nxt.rdata = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            supply_mon_pkg::gate_drive_supply_setting_addr: begin
               st_nxt.rdata = st_r.gate_code; // see (R02)
            end
            supply_mon_pkg::high_supply_threshold_addr: begin
               st_nxt.rdata = st_r.high_lim;
            end
            supply_mon_pkg::low_supply_threshold_addr: begin
               st_nxt.rdata = st_r.low_lim;
            end
            supply_mon_pkg::battery_measurement_addr: begin
               st_nxt.rdata = st_r.bat_meas; // see (R06)
            end
            supply_mon_pkg::die_temperature_addr: begin
               st_nxt.rdata = st_r.die_temp; // see (R11)
            end
            supply_mon_pkg::diag_status_addr: begin
               st_nxt.rdata = status_byte; // see (R12)
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // Reset loads the gate code and limits; every other field starts at zero.
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
         st_r.gate_code <= supply_mon_pkg::GATE_CODE_RST;
         st_r.high_lim <= supply_mon_pkg::HIGH_LIMIT_RST;
         st_r.low_lim <= supply_mon_pkg::LOW_LIMIT_RST;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign gate_supply_code = st_r.gate_code;
   assign fail_silent = st_r.fsilent;
   // Gates stop at once on fail-silent, and two enabled cycles after a lost gate supply.
   assign gates_run = !st_r.fsilent && st_r.good_s[1] && outputs_enabled; // see (R07) see (R09)
   assign low_supply_flag = st_r.low_flag;
   assign high_supply_flag = st_r.high_flag;
endmodule
`default_nettype wire

// ===== verification/mon_chk_assertions.sv
// Purpose: Port checks for the monitor.
// Assumes: One clock domain.
// Notes: Bound after the module.
`default_nettype none
module mon_chk (
   // Watched ports
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire supply_mon_pkg::reg_req_s req,
   input wire logic [7:0] rdata,
   input wire logic outputs_enabled,
   input wire logic off_mode,
   input wire logic [7:0] gate_supply_code,
   input wire logic fail_silent,
   input wire logic gates_run,
   input wire logic low_supply_flag,
   input wire logic high_supply_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_RST: assert property ($fell(rst) |-> gate_supply_code == 8'hb7)
      else $error("bad reset code");
   AST_WR: assert property (clk_en && req.wr && req.addr == 7'h15
      |=> gate_supply_code == $past(req.wdata)) else $error("gate code not stored");
   AST_RD: assert property (clk_en && req.rd && req.addr == 7'h15
      |=> rdata == $past(gate_supply_code)) else $error("gate code misread");
   AST_FLAGS: assert property (clk_en && req.rd && req.addr == 7'h58
      |=> rdata[3:2] == $past({low_supply_flag, high_supply_flag})) else $error("bad flags");
   AST_STOP: assert property (fail_silent |-> !gates_run)
      else $error("gates run while silent");
   AST_LOW: assert property ($rose(low_supply_flag) |-> ##[0:1] fail_silent)
      else $error("no fail-silent");
   AST_HIGH: assert property ($rose(high_supply_flag) |-> ##[0:1] fail_silent)
      else $error("no fail-silent on high flag");
   AST_KEEP: assert property (fail_silent && clk_en && !off_mode |=> fail_silent)
      else $error("fail-silent dropped");
   AST_OFF: assert property (off_mode && clk_en
      |=> !(low_supply_flag || high_supply_flag || fail_silent)) else $error("off kept state");
   AST_ENB: assert property (clk_en && !outputs_enabled
      |=> !$rose(low_supply_flag) && !$rose(high_supply_flag))
      else $error("flag set with outputs off");
   AST_FRZ: assert property (!clk_en |=> $stable(gate_supply_code) && $stable(rdata) &&
      $stable(fail_silent)) else $error("state moved while frozen");
endmodule
bind supply_and_temp_monitor mon_chk chk (.clock(clock), .rst(rst), .clk_en(clk_en), .req(req),
   .rdata(rdata), .outputs_enabled(outputs_enabled), .off_mode(off_mode),
   .gate_supply_code(gate_supply_code),
   .fail_silent(fail_silent), .gates_run(gates_run), .low_supply_flag(low_supply_flag),
   .high_supply_flag(high_supply_flag));
`default_nettype wire

// ===== verification/supply_host.sv
// Purpose: Host model issuing register requests.
// Assumes: Requests change just after an edge.
// Notes: Idle address and data fields are inverted.
`default_nettype none
module supply_host (
   // Bus
   input wire logic clock,
   output var supply_mon_pkg::reg_req_s req,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      logic [7:0] wd;
      wd = d;
      if (w && a == 7'h15 && (d < 8'h5d || d > 8'hb7))
         wd = 8'hb7;
      @(posedge clock);
      #2;
      req = '{w, !w, a, wd};
      @(posedge clock);
      #2;
      q = rdata;
      req = '{1'b0, 1'b0, ~a, ~wd};
   endtask
endmodule
`default_nettype wire

// ===== verification/test_supply_and_temp_monitor.sv
// Purpose: Bench for the monitor.
// Assumes: The bench drives the clock enable and both converter codes.
// Notes: Host model drives requests.
`default_nettype none
module test_supply_and_temp_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, en = 1, good = 1, oe = 0, off = 0, fs, run, lo, hi;
   logic [7:0] bat = 8'h40, tmp = 8'h5a, rdata, code, q;
   supply_mon_pkg::reg_req_s req;
   int n_fail = 0, total_checks = 0, cycles = 0;
   supply_host host (.clock(clock), .req(req), .rdata(rdata));
   supply_and_temp_monitor dut (.clock(clock), .rst(rst), .clk_en(en), .req(req),
      .rdata(rdata), .battery_code_in(bat), .temp_code_in(tmp), .gate_supply_good(good),
      .outputs_enabled(oe), .off_mode(off), .gate_supply_code(code), .fail_silent(fs),
      .gates_run(run), .low_supply_flag(lo), .high_supply_flag(hi));
   initial forever #12.5 clock = ~clock;
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
      host.access(1'b0, a, 8'h00, q);
      check(q & m, e);
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task automatic t_regs;
      rd(7'h15, 8'hb7, 8'hff);
      rd(7'h1a, 8'hff, 8'hff);
      rd(7'h1b, 8'h00, 8'hff);
      host.access(1'b1, 7'h15, 8'h5d, q);
      check(code, 8'h5d);
      rd(7'h15, 8'h5d, 8'hff);
      host.access(1'b1, 7'h1b, 8'h30, q);
      host.access(1'b1, 7'h1a, 8'hc0, q);
      rd(7'h1b, 8'h30, 8'hff);
      rd(7'h1a, 8'hc0, 8'hff);
   endtask
   task automatic t_meas;
      oe = 1;
      w(8);
      rd(7'h45, 8'h40, 8'hff);
      host.access(1'b1, 7'h45, 8'h99, q);
      rd(7'h45, 8'h40, 8'hff);
      rd(7'h46, 8'h5a, 8'hff);
      tmp = 8'h82;
      w(8);
      rd(7'h46, 8'h82, 8'hff);
      oe = 0;
      good = 0;
      bat = 8'h60;
      w(8);
      rd(7'h45, 8'h40, 8'hff);
      oe = 1;
      w(8);
      rd(7'h45, 8'h40, 8'hff);
      check(run, 8'h00);
      good = 1;
      w(8);
      rd(7'h45, 8'h60, 8'hff);
      check({run, fs, lo, hi}, 8'h08);
   endtask
   task automatic t_freeze;
      en = 0;
      host.access(1'b1, 7'h15, 8'h90, q);
      host.access(1'b1, 7'h1b, 8'h11, q);
      bat = 8'h10;
      w(8);
      check(code, 8'h5d);
      check({fs, lo}, 8'h00);
      bat = 8'h60;
      en = 1;
      rd(7'h1b, 8'h30, 8'hff);
   endtask
   task automatic t_fault;
      bat = 8'h20;
      w(8);
      check({run, fs, lo, hi}, 8'h06);
      rd(7'h58, 8'h08, 8'h0c);
      bat = 8'h60;
      w(8);
      host.access(1'b1, 7'h58, 8'h00, q);
      w(1);
      check({fs, lo}, 8'h02);
      off = 1;
      w(1);
      off = 0;
      w(1);
      check({run, fs}, 8'h02);
      bat = 8'hd0;
      w(8);
      check({run, fs, hi}, 8'h03);
      rd(7'h58, 8'h04, 8'h0c);
   endtask
   task automatic t_reset;
      rst = 1;
      w(2);
      check(code, 8'hb7);
      rst = 0;
      rd(7'h1a, 8'hff, 8'hff);
      rd(7'h1b, 8'h00, 8'hff);
   endtask
   task automatic complete_run;
      if (n_fail == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         complete_run;
      end
   end
   initial begin
      w(8);
      rst = 0;
      t_regs;
      t_meas;
      t_freeze;
      t_fault;
      t_reset;
      complete_run;
   end
endmodule
`default_nettype wire
